// ==== src/udpsf_framer.sv ====
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "udpsf_defines.svh"
module udpsf_framer (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_we_in,
  input wire logic reg_re_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [31:0] cmd_src_ip_in,
  input wire udpsf_pkg::udpsf_sample_s sample_in,
  input wire udpsf_pkg::udpsf_cond_s cond_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_first_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  output udpsf_pkg::udpsf_dgram_s dgram_out,
  output logic irq_out
);
  function automatic logic [10:0] udpsf_data_len(input logic [1:0] code);
    return `UDPSF_MAX_DATA >> code;
  endfunction

  function automatic logic [4:0] udpsf_samp_len(input logic [2:0] cont);
    logic [4:0] n;
    n = (cont[1:0] == 2'h0) ? 5'h01 : ((cont[1:0] == 2'h3) ? 5'h04 : 5'h02);
    return cont[2] ? {n[3:0], 1'b0} : {n[2:0], 2'b00};
  endfunction

  // Word index in X, Y, R, phase order for the i-th quantity of a sample
  function automatic logic [1:0] udpsf_qty(input logic [1:0] cont, input logic [1:0] i);
    return (cont == 2'h2) ? (i + 2'h2) : i;
  endfunction

  udpsf_pkg::udpsf_cfg_s cfg_q;
  udpsf_pkg::udpsf_cfg_s run_q;
  logic [15:0] port_q;
  logic [15:0] dport_q;
  logic [31:0] dip_q;
  logic run_en_q;
  logic [4:0] base_cnt_q;
  logic [31:0] sub_cnt_q;
  logic base_tick;
  logic capture;
  udpsf_pkg::udpsf_cap_s cap_q;
  logic ser_busy_q;
  logic [3:0] ser_k_q;
  logic half;
  logic [4:0] samp_len;
  logic [1:0] qi;
  logic [1:0] bi;
  logic [31:0] ser_word;
  logic [7:0] ser_byte;
  logic [7:0] mem_q [0:2047];
  logic fb_q;
  logic [10:0] fcnt_q;
  logic [1:0] full_q;
  logic [1:0][1:0] bstat_q;
  logic [10:0] bank_len;
  logic last_wr;
  logic tgt;
  logic accept;
  logic drop_ev;
  udpsf_pkg::udpsf_tx_e st_q;
  logic tb_q;
  logic [10:0] nidx_q;
  logic [10:0] tx_len_q;
  logic [10:0] didx;
  logic [31:0] hdr_q;
  logic [31:0] hdr_d;
  logic [7:0] nxt_byte;
  logic [7:0] pkt_cnt_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic tx_first_q;
  logic tx_last_q;
  udpsf_pkg::udpsf_dgram_s dgram_q;
  logic tx_done;
  logic ovl_now;
  logic err_now;
  logic [31:0] rdata_q;
  logic [1:0] istat;
  logic [1:0] imask;
  logic wr_ctrl;

  assign wr_ctrl = reg_we_in && (reg_addr_in == `UDPSF_A_CTRL);

  // Configuration written by the command side
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg_q <= '0;
      port_q <= `UDPSF_PORT_RST;
    end else if (ce_in && reg_we_in) begin
      unique case (reg_addr_in)
        `UDPSF_A_PORT: port_q <= reg_wdata_in[15:0];
        `UDPSF_A_OPT: begin
          cfg_q.little <= reg_wdata_in[`UDPSF_OPT_LE];
          cfg_q.csum <= reg_wdata_in[`UDPSF_OPT_CS];
        end
        `UDPSF_A_SIZE: cfg_q.size <= reg_wdata_in[1:0];
        `UDPSF_A_CONT: cfg_q.content <= reg_wdata_in[2:0];
        `UDPSF_A_RATE: cfg_q.rate <= reg_wdata_in[4:0];
        default: begin
        end
      endcase
    end
  end

  // Settings freeze at enable so a datagram never mixes layouts
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      run_en_q <= 1'b0;
      run_q <= '0;
      dip_q <= 32'h0000_0000;
      dport_q <= `UDPSF_PORT_RST;
    end else if (ce_in && wr_ctrl) begin
      run_en_q <= reg_wdata_in[`UDPSF_CTRL_EN];
      if (reg_wdata_in[`UDPSF_CTRL_EN]) begin
        run_q <= cfg_q;
        dip_q <= cmd_src_ip_in;
        dport_q <= port_q;
      end
    end
  end

  // Base sample tick and subsampling by two to the N
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      base_cnt_q <= 5'h00;
    end else if (ce_in) begin
      if (!run_en_q || base_tick) begin
        base_cnt_q <= 5'h00;
      end else begin
        base_cnt_q <= base_cnt_q + 5'h01;
      end
    end
  end

  assign base_tick = run_en_q && (base_cnt_q == 5'(`UDPSF_BASE_CYC - 1));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sub_cnt_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (!run_en_q) begin
        sub_cnt_q <= 32'h0000_0000;
      end else if (base_tick) begin
        if (sub_cnt_q == 32'h0000_0000) begin
          sub_cnt_q <= (32'h0000_0001 << run_q.rate) - 32'h0000_0001;
        end else begin
          sub_cnt_q <= sub_cnt_q - 32'h0000_0001;
        end
      end
    end
  end

  assign capture = base_tick && (sub_cnt_q == 32'h0000_0000);
  assign half = run_q.content[2];
  assign samp_len = udpsf_samp_len(run_q.content);
  assign ovl_now = cond_in.in_ovl | (cond_in.sync_on & cond_in.sync_ovl)
    | (half & cond_in.out_ovl);
  assign err_now = cond_in.pll_unlock | cond_in.sync_oor;

  // Bank targeting: the byte that completes a bank moves filling to the other
  assign bank_len = udpsf_data_len(run_q.size);
  assign last_wr = ser_busy_q && ((fcnt_q + 11'h001) == bank_len);
  assign tgt = last_wr ? ~fb_q : fb_q;
  assign accept = capture && !full_q[tgt];
  assign drop_ev = capture && full_q[tgt];

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cap_q <= '0;
    end else if (ce_in && accept) begin
      for (int i = 0; i < 4; i++) begin
        cap_q.w[i] <= half ? {16'h0000, sample_in.fix[i]} : sample_in.flt[i];
      end
      cap_q.ovl <= ovl_now;
      cap_q.err <= err_now;
    end
  end

  // One byte per cycle; a full-rate float sample just fits the tick spacing
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ser_busy_q <= 1'b0;
      ser_k_q <= 4'h0;
    end else if (ce_in) begin
      if (!run_en_q) begin
        ser_busy_q <= 1'b0;
      end else if (accept) begin
        ser_busy_q <= 1'b1;
        ser_k_q <= 4'h0;
      end else if (ser_busy_q) begin
        if (ser_k_q == 4'(samp_len - 5'h01)) begin
          ser_busy_q <= 1'b0;
        end
        ser_k_q <= ser_k_q + 4'h1;
      end
    end
  end

  assign qi = half ? ser_k_q[2:1] : ser_k_q[3:2];
  assign bi = half ? {1'b0, ser_k_q[0]} : ser_k_q[1:0];
  assign ser_word = cap_q.w[udpsf_qty(run_q.content[1:0], qi)];

  udpsf_byte_order u_order (
    .word_in(ser_word),
    .half_in(half),
    .little_in(run_q.little),
    .idx_in(bi),
    .byte_out(ser_byte)
  );

  always_ff @(posedge mclk_in) begin
    if (ce_in && ser_busy_q) begin
      mem_q[{fb_q, fcnt_q[9:0]}] <= ser_byte;
    end
  end

  // Two banks: one fills while the other is sent
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fb_q <= 1'b0;
      fcnt_q <= 11'h000;
      full_q <= 2'h0;
      bstat_q <= '0;
    end else if (ce_in) begin
      if (!run_en_q) begin
        fcnt_q <= 11'h000;
        fb_q <= (st_q != udpsf_pkg::UDPSF_IDLE) ? ~tb_q : tb_q;
        full_q <= (st_q != udpsf_pkg::UDPSF_IDLE && !tx_done) ?
          (full_q & (2'h1 << tb_q)) : 2'h0;
      end else begin
        if (ser_busy_q) begin
          if (ser_busy_q && fcnt_q == 11'h000) begin
            bstat_q[fb_q] <= {cap_q.err, cap_q.ovl};
          end
          if (last_wr) begin
            fcnt_q <= 11'h000;
            fb_q <= ~fb_q;
          end else begin
            fcnt_q <= fcnt_q + 11'h001;
          end
        end
        full_q <= (full_q & ~(tx_done ? (2'h1 << tb_q) : 2'h0))
          | (last_wr ? (2'h1 << fb_q) : 2'h0);
      end
    end
  end

  // Header fields
  always_comb begin
    hdr_d = 32'h0000_0000;
    hdr_d[`UDPSF_H_OVL] = bstat_q[tb_q][0];
    hdr_d[`UDPSF_H_ERR] = bstat_q[tb_q][1];
    hdr_d[`UDPSF_H_LE] = run_q.little;
    hdr_d[`UDPSF_H_CS] = run_q.csum;
    hdr_d[`UDPSF_H_RATE +: 8] = {3'h0, run_q.rate};
    hdr_d[`UDPSF_H_SIZE +: 4] = {2'h0, run_q.size};
    hdr_d[`UDPSF_H_CONT +: 4] = {1'b0, run_q.content};
    hdr_d[`UDPSF_H_CNT +: 8] = pkt_cnt_q;
  end

  assign didx = nidx_q - `UDPSF_HDR_BYTES;
  assign nxt_byte = (nidx_q < `UDPSF_HDR_BYTES) ?
    hdr_q[{2'h3 - nidx_q[1:0], 3'h0} +: 8] : mem_q[{tb_q, didx[9:0]}];
  assign tx_done = (st_q == udpsf_pkg::UDPSF_DONE);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q <= udpsf_pkg::UDPSF_IDLE;
      tb_q <= 1'b0;
      nidx_q <= 11'h000;
      tx_len_q <= 11'h000;
      hdr_q <= 32'h0000_0000;
      dgram_q <= '0;
      pkt_cnt_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_first_q <= 1'b0;
      tx_last_q <= 1'b0;
    end else if (ce_in) begin
      unique case (st_q)
        udpsf_pkg::UDPSF_IDLE: begin
          if (full_q[tb_q]) begin
            st_q <= udpsf_pkg::UDPSF_HDR;
            nidx_q <= 11'h000;
            tx_len_q <= `UDPSF_HDR_BYTES + bank_len;
            hdr_q <= hdr_d;
            dgram_q.dest_ip <= dip_q;
            dgram_q.dest_port <= dport_q;
            dgram_q.csum_en <= run_q.csum;
            dgram_q.length <= 16'(`UDPSF_HDR_BYTES + bank_len);
          end
        end
        udpsf_pkg::UDPSF_HDR, udpsf_pkg::UDPSF_DATA: begin
          if (!tx_valid_q || tx_ready_in) begin
            if (nidx_q < tx_len_q) begin
              tx_valid_q <= 1'b1;
              tx_data_q <= nxt_byte;
              tx_first_q <= (nidx_q == 11'h000);
              tx_last_q <= (nidx_q == tx_len_q - 11'h001);
              nidx_q <= nidx_q + 11'h001;
              if (nidx_q == `UDPSF_HDR_BYTES - 11'h001) begin
                st_q <= udpsf_pkg::UDPSF_DATA;
              end
            end else begin
              tx_valid_q <= 1'b0;
              tx_first_q <= 1'b0;
              tx_last_q <= 1'b0;
              st_q <= udpsf_pkg::UDPSF_DONE;
            end
          end
        end
        udpsf_pkg::UDPSF_DONE: begin
          st_q <= udpsf_pkg::UDPSF_IDLE;
          tb_q <= ~tb_q;
          pkt_cnt_q <= pkt_cnt_q + 8'h01;
        end
      endcase
    end
  end

  udpsf_irq u_irq (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .event_in({drop_ev, tx_done}),
    .clr_we_in(reg_we_in && (reg_addr_in == `UDPSF_A_ISTAT)),
    .clr_in(reg_wdata_in[1:0]),
    .mask_we_in(reg_we_in && (reg_addr_in == `UDPSF_A_IMASK)),
    .mask_in(reg_wdata_in[1:0]),
    .stat_out(istat),
    .mask_out(imask),
    .irq_out(irq_out)
  );

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_in) begin
      rdata_q <= 32'h0000_0000;
      if (reg_re_in) begin
        unique case (reg_addr_in)
          `UDPSF_A_CTRL: rdata_q <= {31'h0000_0000, run_en_q};
          `UDPSF_A_PORT: rdata_q <= {16'h0000, port_q};
          `UDPSF_A_OPT: rdata_q <= {30'h0000_0000, cfg_q.csum, cfg_q.little};
          `UDPSF_A_SIZE: rdata_q <= {30'h0000_0000, cfg_q.size};
          `UDPSF_A_CONT: rdata_q <= {29'h0000_0000, cfg_q.content};
          `UDPSF_A_RATE: rdata_q <= {27'h000_0000, cfg_q.rate};
          `UDPSF_A_DEST: rdata_q <= dip_q;
          `UDPSF_A_STAT: rdata_q <= {21'h00_0000, full_q,
            st_q != udpsf_pkg::UDPSF_IDLE, pkt_cnt_q};
          `UDPSF_A_ISTAT: rdata_q <= {30'h0000_0000, istat};
          `UDPSF_A_IMASK: rdata_q <= {30'h0000_0000, imask};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign tx_valid_out = tx_valid_q;
  assign tx_data_out = tx_data_q;
  assign tx_first_out = tx_first_q;
  assign tx_last_out = tx_last_q;
  assign dgram_out = dgram_q;

  dest_ip_a: assert property (@(posedge mclk_in) disable iff (rst_in || !ce_in)
    wr_ctrl && reg_wdata_in[0] |=> dip_q == $past(cmd_src_ip_in))
    else $error("destination IP not taken from command source");

  dest_load_a: assert property (@(posedge mclk_in) disable iff (rst_in || !ce_in)
    (st_q == udpsf_pkg::UDPSF_IDLE && full_q[tb_q])
    |=> dgram_out.dest_port == $past(dport_q) && dgram_out.dest_ip == $past(dip_q))
    else $error("datagram address not loaded at start");

  hdr_msb_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    tx_valid_out && tx_first_out |-> tx_data_out == hdr_q[31:24])
    else $error("header not sent most significant byte first");

  len_field_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    tx_valid_out && tx_first_out |-> hdr_q[15:14] == 2'h0
      && dgram_out.length == 16'(`UDPSF_HDR_BYTES + udpsf_data_len(hdr_q[13:12])))
    else $error("length code and datagram length disagree");

  cnt_step_a: assert property (@(posedge mclk_in) disable iff (rst_in || !ce_in)
    tx_done |=> pkt_cnt_q == $past(pkt_cnt_q) + 8'h01)
    else $error("packet counter did not step by one");

  last_len_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    tx_valid_out && tx_last_out |-> nidx_q == tx_len_q && tx_len_q >= 11'h084)
    else $error("last byte not at configured length");

  flag_bits_a: assert property (@(posedge mclk_in) disable iff (rst_in || !ce_in)
    (st_q == udpsf_pkg::UDPSF_IDLE && full_q[tb_q])
    |=> hdr_q[`UDPSF_H_LE] == $past(run_q.little) && hdr_q[`UDPSF_H_CS] == dgram_out.csum_en)
    else $error("endian or checksum flag wrong");

  ovl_first_a: assert property (@(posedge mclk_in) disable iff (rst_in || !ce_in)
    run_en_q && ser_busy_q && fcnt_q == 11'h000
    |=> bstat_q[$past(fb_q)] == $past({cap_q.err, cap_q.ovl}))
    else $error("status not caught at first sample");

  ord_first_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ser_busy_q && run_q.content[1:0] == 2'h2 && qi == 2'h0 |-> ser_word == cap_q.w[2])
    else $error("magnitude not first in R-phase sample");
endmodule

// ==== common/udpsf_defines.svh ====
`ifndef UDPSF_DEFINES_SVH
`define UDPSF_DEFINES_SVH

// Register byte offsets
`define UDPSF_A_CTRL 8'h00
`define UDPSF_A_PORT 8'h04
`define UDPSF_A_OPT 8'h08
`define UDPSF_A_SIZE 8'h0C
`define UDPSF_A_CONT 8'h10
`define UDPSF_A_RATE 8'h14
`define UDPSF_A_DEST 8'h18
`define UDPSF_A_STAT 8'h1C
`define UDPSF_A_ISTAT 8'h20
`define UDPSF_A_IMASK 8'h24

// Reset values
`define UDPSF_PORT_RST 16'h0749
`define UDPSF_IMASK_RST 2'h0

// Field positions
`define UDPSF_CTRL_EN 0
`define UDPSF_OPT_LE 0
`define UDPSF_OPT_CS 1
`define UDPSF_H_OVL 24
`define UDPSF_H_ERR 25
`define UDPSF_H_LE 28
`define UDPSF_H_CS 29
`define UDPSF_H_RATE 16
`define UDPSF_H_SIZE 12
`define UDPSF_H_CONT 8
`define UDPSF_H_CNT 0
`define UDPSF_EV_SENT 0
`define UDPSF_EV_DROP 1

// Sizes
`define UDPSF_HDR_BYTES 11'h004
`define UDPSF_MAX_DATA 11'h400

// Timing
`define UDPSF_CLK_NS 50
`define UDPSF_BASE_NS 800
`define UDPSF_BASE_CYC ((`UDPSF_BASE_NS) / (`UDPSF_CLK_NS))

`endif

// ==== common/udpsf_pkg.sv ====
package udpsf_pkg;

  typedef struct packed {
    logic [3:0][31:0] flt;
    logic [3:0][15:0] fix;
  } udpsf_sample_s;

  typedef struct packed {
    logic in_ovl;
    logic sync_on;
    logic sync_ovl;
    logic out_ovl;
    logic pll_unlock;
    logic sync_oor;
  } udpsf_cond_s;

  typedef struct packed {
    logic little;
    logic csum;
    logic [1:0] size;
    logic [2:0] content;
    logic [4:0] rate;
  } udpsf_cfg_s;

  typedef struct packed {
    logic [31:0] dest_ip;
    logic [15:0] dest_port;
    logic csum_en;
    logic [15:0] length;
  } udpsf_dgram_s;

  typedef struct packed {
    logic [3:0][31:0] w;
    logic ovl;
    logic err;
  } udpsf_cap_s;

  typedef enum logic [1:0] {
    UDPSF_IDLE = 2'b00,
    UDPSF_HDR = 2'b01,
    UDPSF_DATA = 2'b11,
    UDPSF_DONE = 2'b10
  } udpsf_tx_e;

endpackage

// ==== src/udpsf_byte_order.sv ====
`timescale 1ns/10ps
module udpsf_byte_order (
  input wire logic [31:0] word_in,
  input wire logic half_in,
  input wire logic little_in,
  input wire logic [1:0] idx_in,
  output logic [7:0] byte_out
);
  logic [1:0] lane;

  always_comb begin
    lane = idx_in;
    if (!little_in) begin
      lane = half_in ? (2'h1 - idx_in) : (2'h3 - idx_in);
    end
    // Whole bytes move, bit order inside stays
    byte_out = word_in[{lane, 3'h0} +: 8];
  end
endmodule

// ==== src/udpsf_irq.sv ====
`timescale 1ns/10ps
`include "udpsf_defines.svh"
module udpsf_irq (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [1:0] event_in,
  input wire logic clr_we_in,
  input wire logic [1:0] clr_in,
  input wire logic mask_we_in,
  input wire logic [1:0] mask_in,
  output logic [1:0] stat_out,
  output logic [1:0] mask_out,
  output logic irq_out
);
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic irq_q;

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      stat_q <= 2'h0;
    end else if (ce_in) begin
      stat_q <= (stat_q & ~(clr_we_in ? clr_in : 2'h0)) | event_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mask_q <= `UDPSF_IMASK_RST;
    end else if (ce_in && mask_we_in) begin
      mask_q <= mask_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
    end else if (ce_in) begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign stat_out = stat_q;
  assign mask_out = mask_q;
  assign irq_out = irq_q;

  set_wins_a: assert property (@(posedge mclk_in) disable iff (rst_in || !ce_in)
    event_in[0] |=> stat_q[0])
    else $error("event lost against clear");
endmodule

// ==== verif/udpsf_host_model.sv ====
`timescale 1ns/10ps
module udpsf_host_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_first_in,
  input wire logic tx_last_in,
  output logic tx_ready_out
);
  logic [7:0] rx_q [0:1027];
  int len_q;
  int pkts_q;
  logic ph_q;
  // Slow mode takes every other byte, so the framer must hold its byte
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
    end
  end
  assign tx_ready_out = ~slow_in | ph_q;
  // A datagram counts as delivered only once its last byte is in
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      len_q <= 0;
      pkts_q <= 0;
    end else if (tx_valid_in && tx_ready_out) begin
      rx_q[tx_first_in ? 0 : len_q] <= tx_data_in;
      len_q <= tx_first_in ? 1 : len_q + 1;
      if (tx_last_in) begin
        pkts_q <= pkts_q + 1;
      end
    end
  end
endmodule

// ==== verif/udpsf_framer_tb.sv ====
`timescale 1ns/10ps
`include "udpsf_defines.svh"
module udpsf_framer_tb;
  localparam logic [3:0][31:0] FV = {32'h7A8B9CAD, 32'h5E6F7081, 32'h33445566, 32'h11223344};
  localparam logic [3:0][15:0] IV = {16'h0000, 16'h0000, 16'hC3D4, 16'hA1B2};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  logic [31:0] src_ip = 32'h0;
  udpsf_pkg::udpsf_sample_s smp = '0;
  udpsf_pkg::udpsf_cond_s cond = '0;
  logic tx_valid, tx_first, tx_last, tx_ready, irq, slow = 1'b0;
  logic [7:0] tx_data;
  udpsf_pkg::udpsf_dgram_s dg;
  logic [31:0] r;
  logic [7:0] c1;
  int miscompares = 0;
  int checked = 0;
  int n0;
  udpsf_framer dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_we_in(we), .reg_re_in(re), .reg_rdata_out(rdata),
    .cmd_src_ip_in(src_ip), .sample_in(smp), .cond_in(cond), .tx_valid_out(tx_valid),
    .tx_data_out(tx_data), .tx_first_out(tx_first), .tx_last_out(tx_last),
    .tx_ready_in(tx_ready), .dgram_out(dg), .irq_out(irq));
  udpsf_host_model host (.mclk_in(mclk_in), .rst_in(rst_in), .slow_in(slow),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_first_in(tx_first),
    .tx_last_in(tx_last), .tx_ready_out(tx_ready));
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge mclk_in);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk_in);
    re <= 1'b0;
    @(negedge mclk_in);
    d = rdata;
  endtask
  task automatic wait_pkts(input int n);
    int k;
    for (k = 0; k < 12000 && host.pkts_q < n; k++) begin
      @(negedge mclk_in);
    end
    chk("datagram_count", host.pkts_q, n);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk_in);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(`UDPSF_A_PORT, r);
    chk("port_reset", r, 32'h0749);
    rd(`UDPSF_A_IMASK, r);
    chk("mask_reset", r, 32'h0);
    rd(8'h30, r);
    chk("unmapped", r, 32'h0);
    $display("test reset done");
    // Float XYRt, 128 bytes, checksum on, slow receiver forces drops
    smp.flt <= FV;
    smp.fix <= IV;
    cond.in_ovl <= 1'b1;
    slow <= 1'b1;
    src_ip <= 32'hC0A80017;
    wr(`UDPSF_A_OPT, 32'h2);
    wr(`UDPSF_A_SIZE, 32'h3);
    wr(`UDPSF_A_CONT, 32'h3);
    wr(`UDPSF_A_RATE, 32'h0);
    wr(`UDPSF_A_CTRL, 32'h1);
    wait_pkts(1);
    chk("dest_ip", dg.dest_ip, 32'hC0A80017);
    chk("dest_port", dg.dest_port, 32'h0749);
    chk("csum_en", dg.csum_en, 1'b1);
    chk("length", dg.length, 32'h0084);
    chk("hdr_status", host.rx_q[0], 8'h21);
    chk("hdr_rate", host.rx_q[1], 8'h00);
    chk("hdr_size_cont", host.rx_q[2], 8'h33);
    for (int i = 0; i < 128; i++) begin
      chk("data_be", host.rx_q[4 + i], FV[(i % 16) / 4][31 - 8 * (i % 4) -: 8]);
    end
    c1 = host.rx_q[3];
    wait_pkts(2);
    chk("hdr_count", host.rx_q[3], 8'(c1 + 8'h01));
    rd(`UDPSF_A_ISTAT, r);
    chk("istat_sent", r[0], 1'b1);
    chk("irq_masked", irq, 1'b0);
    wr(`UDPSF_A_IMASK, 32'h3);
    repeat (2) @(negedge mclk_in);
    chk("irq_on", irq, 1'b1);
    wr(`UDPSF_A_CTRL, 32'h0);
    repeat (600) @(posedge mclk_in);
    wr(`UDPSF_A_ISTAT, 32'h3);
    rd(`UDPSF_A_ISTAT, r);
    chk("istat_clear", r, 32'h0);
    repeat (2) @(negedge mclk_in);
    chk("irq_off", irq, 1'b0);
    wr(`UDPSF_A_IMASK, 32'h0);
    $display("test float big-endian done");
    // Integer XY, 256 bytes, little-endian data, unlock flagged
    n0 = host.pkts_q;
    slow <= 1'b0;
    cond.in_ovl <= 1'b0;
    cond.pll_unlock <= 1'b1;
    src_ip <= 32'h0A000105;
    wr(`UDPSF_A_PORT, 32'h1234);
    wr(`UDPSF_A_OPT, 32'h1);
    wr(`UDPSF_A_SIZE, 32'h2);
    wr(`UDPSF_A_CONT, 32'h5);
    wr(`UDPSF_A_RATE, 32'h3);
    wr(`UDPSF_A_CTRL, 32'h1);
    wait_pkts(n0 + 1);
    chk("dest_ip_b", dg.dest_ip, 32'h0A000105);
    chk("dest_port_b", dg.dest_port, 32'h1234);
    chk("csum_off", dg.csum_en, 1'b0);
    chk("length_b", dg.length, 32'h0104);
    chk("hdr_status_b", host.rx_q[0], 8'h12);
    chk("hdr_rate_b", host.rx_q[1], 8'h03);
    chk("hdr_size_cont_b", host.rx_q[2], 8'h25);
    // Receiver view: integers swapped two bytes at a time
    for (int i = 0; i < 256; i++) begin
      chk("data_le", host.rx_q[4 + i], IV[(i % 4) / 2][8 * (i % 2) +: 8]);
    end
    wr(`UDPSF_A_CTRL, 32'h0);
    $display("test integer little-endian done");
    // Float R-phase; output overload must not flag a float datagram
    n0 = host.pkts_q;
    cond.pll_unlock <= 1'b0;
    cond.out_ovl <= 1'b1;
    cond.sync_on <= 1'b1;
    wr(`UDPSF_A_OPT, 32'h0);
    wr(`UDPSF_A_SIZE, 32'h3);
    wr(`UDPSF_A_CONT, 32'h2);
    wr(`UDPSF_A_RATE, 32'h0);
    // Write while frozen must be lost
    ce <= 1'b0;
    wr(`UDPSF_A_PORT, 32'h5555);
    ce <= 1'b1;
    rd(`UDPSF_A_PORT, r);
    chk("port_frozen", r, 32'h1234);
    wr(`UDPSF_A_CTRL, 32'h1);
    wait_pkts(n0 + 1);
    chk("dest_port_c", dg.dest_port, 32'h1234);
    chk("hdr_status_c", host.rx_q[0], 8'h00);
    chk("hdr_size_cont_c", host.rx_q[2], 8'h32);
    for (int i = 0; i < 128; i++) begin
      chk("data_rp", host.rx_q[4 + i], FV[2 + (i % 8) / 4][31 - 8 * (i % 4) -: 8]);
    end
    wr(`UDPSF_A_CTRL, 32'h0);
    $display("test float magnitude-phase done");
    conclude();
  end
endmodule
